// [hdl/sac_cache.v]
// four-way set-associative write-back data cache, 128 lines of four-word blocks
// assumes requests are already physical (page test passed or unpaged) and that
// core memory returns fill words in the order it is asked and drains the buffer
//
// Functional notes
// - words are 36 bits, physical addresses 22 bits.
// - address splits into 13-bit page, 7-bit quadword, 2-bit word.
// - 2048 data words, each with own valid and written flag.
// - 512 blocks in 128 lines of four; low nine bits reach whole line.
// - a memory block fills only its line, in the least recently used way.
// - block writes also update directory address and valid flags.
// - written flags set only by processor stores, never by memory fills.
// - stores never write through; memory updated only by writeback.
// - a block holds the quadword when address matches and any valid set.
// - read hit on valid word reads the cache with no memory cycle.
// - partial hit refills all invalid words, requested first, then ascending with wraparound.
// - first fill word goes to processor; each stored word sets valid.
// - on a miss the LRU block is reused directly only if clean.
// - write miss into clean block writes word and directory, no memory.
// - read miss into clean block records page, reads all four words.
// - dirty victim is written back, clearing each written flag as moved.
// - after all written words leave, the pending request is retried.
// - memory write starts as soon as the first word is buffered.
`timescale 1ns/1ps
`include "sac_consts.vh"
module sac_cache (
    input  wire                     clock,
    input  wire                     rst_n,
    input  wire                     req_valid,
    output wire                     req_ready,
    input  wire                     req_write,
    input  wire [`SAC_ADDR_W-1:0]   req_addr,
    input  wire [`SAC_WORD_W-1:0]   req_wdata,
    output wire                     resp_valid,
    output wire [`SAC_WORD_W-1:0]   resp_rdata,
    output wire                     mem_rd_valid,
    input  wire                     mem_rd_ready,
    output wire [`SAC_QADDR_W-1:0]  mem_rd_addr,
    output wire [1:0]               mem_rd_first,
    output wire [3:0]               mem_rd_mask,
    input  wire                     mem_rdata_valid,
    input  wire [1:0]               mem_rdata_word,
    input  wire [`SAC_WORD_W-1:0]   mem_rdata,
    output wire                     mem_wr_start,
    output wire [`SAC_QADDR_W-1:0]  mem_wr_addr,
    output wire                     mb_valid,
    input  wire                     mb_ready,
    output wire [`SAC_ADDR_W-1:0]   mb_addr,
    output wire [`SAC_WORD_W-1:0]   mb_data
);

    // ==========================================================
    // states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_LOOK = 3'h1;
    localparam [2:0] ST_FREQ = 3'h2;
    localparam [2:0] ST_FILL = 3'h3;
    localparam [2:0] ST_WB   = 3'h4;

    // ==========================================================
    // storage: data, directory, use order
    reg [`SAC_WORD_W-1:0] data_mem [0:`SAC_WORDS-1];
    reg [`SAC_PAGE_W-1:0] tag_mem  [0:`SAC_BLOCKS-1];
    reg [3:0]             vld_q    [0:`SAC_BLOCKS-1];
    reg [3:0]             wrt_q    [0:`SAC_BLOCKS-1];
    reg [7:0]             use_q    [0:`SAC_LINES-1];

    // ==========================================================
    // request and control registers
    reg [2:0]               state_q;
    reg [`SAC_ADDR_W-1:0]   addr_q;
    reg                     wr_q;
    reg [`SAC_WORD_W-1:0]   wdata_q;
    reg [1:0]               way_q;
    reg [3:0]               mask_q;
    reg                     first_q;
    reg                     resp_valid_q;
    reg [`SAC_WORD_W-1:0]   resp_rdata_q;
    reg                     wb_started_q;
    reg                     mem_wr_start_q;
    reg [`SAC_QADDR_W-1:0]  mem_wr_addr_q;

    // ==========================================================
    // address fields of the pending request
    wire [`SAC_PAGE_W-1:0] page = addr_q[`SAC_PAGE_MSB:`SAC_PAGE_LSB];
    wire [`SAC_LINE_W-1:0] line = addr_q[`SAC_LINE_MSB:`SAC_LINE_LSB];
    wire [1:0]             wsel = addr_q[`SAC_WSEL_MSB:`SAC_WSEL_LSB];
    wire [3:0]             word_bit = 4'h1 << wsel;

    // ==========================================================
    // helpers
    // move a way to the most recent slot, keeping the others in order
    function [7:0] use_touch;
        input [7:0] ord;
        input [1:0] way;
        integer     i;
        reg [7:0]   r;
        reg [2:0]   n;
        begin
            r = {6'h00, way};
            n = 3'h1;
            for (i = 0; i < 4; i = i + 1) begin
                if (ord[2*i +: 2] != way) begin
                    r[2*n +: 2] = ord[2*i +: 2];
                    n = n + 3'h1;
                end
            end
            use_touch = r;
        end
    endfunction

    function [1:0] low_set;
        input [3:0] v;
        begin
            low_set = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
        end
    endfunction

    // ==========================================================
    // directory compare, all four ways of the line at once
    wire [3:0] hit_vec;
    genvar w;
    generate
        for (w = 0; w < `SAC_WAYS; w = w + 1) begin : g_way
            localparam [1:0] WI = w;
            assign hit_vec[w] = (tag_mem[{WI, line}] == page) &&
                                (|vld_q[{WI, line}]);
        end
    endgenerate

    wire       hit_any = |hit_vec;
    wire [1:0] hit_way = hit_vec[3] ? 2'h3 : hit_vec[2] ? 2'h2 : hit_vec[1] ? 2'h1 : 2'h0;
    wire [7:0] use_cur = use_q[line];
    wire [1:0] victim  = use_cur[7:6];
    wire [1:0] sel_way = hit_any ? hit_way : victim;
    wire [8:0] sel_blk = {sel_way, line};
    wire [3:0] sel_vld = vld_q[sel_blk];
    wire [3:0] sel_wrt = wrt_q[sel_blk];
    wire       vic_dirty = !hit_any && (|sel_wrt);

    // ==========================================================
    // writeback source: lowest written word of the victim block
    wire [8:0]  wb_blk  = {way_q, line};
    wire [3:0]  wb_wrt  = wrt_q[wb_blk];
    wire [1:0]  wb_idx  = low_set(wb_wrt);
    wire        wb_push_valid = (state_q == ST_WB) && (|wb_wrt);
    wire        wb_push_ready;
    wire        wb_push = wb_push_valid && wb_push_ready;
    wire [`SAC_ADDR_W+`SAC_WORD_W-1:0] wb_entry;
    wire [`SAC_ADDR_W+`SAC_WORD_W-1:0] mb_entry;

    assign wb_entry = {tag_mem[wb_blk], line, wb_idx, data_mem[{wb_blk, wb_idx}]};

    // ==========================================================
    // data and tag write port
    wire look_wr   = (state_q == ST_LOOK) && wr_q && !vic_dirty;
    wire fill_wr   = (state_q == ST_FILL) && mem_rdata_valid;
    wire look_rmiss = (state_q == ST_LOOK) && !wr_q && !hit_any && !vic_dirty;
    reg                     dwe;
    reg [10:0]              dwaddr;
    reg [`SAC_WORD_W-1:0]   dwdata;

    always @* begin
        dwe    = 1'b0;
        dwaddr = {sel_blk, wsel};
        dwdata = wdata_q;
        if (look_wr) begin
            dwe = 1'b1;
        end else if (fill_wr) begin
            dwe    = 1'b1;
            dwaddr = {way_q, line, mem_rdata_word};
            dwdata = mem_rdata;
        end
    end

    always @(posedge clock) begin
        if (dwe) begin
            data_mem[dwaddr] <= dwdata;
        end
        if (look_wr || look_rmiss) begin
            tag_mem[sel_blk] <= page;
        end
    end

    // ==========================================================
    // control, directory flags and use order
    integer k;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q        <= ST_IDLE;
            addr_q         <= {`SAC_ADDR_W{1'b0}};
            wr_q           <= 1'b0;
            wdata_q        <= {`SAC_WORD_W{1'b0}};
            way_q          <= 2'h0;
            mask_q         <= 4'h0;
            first_q        <= 1'b0;
            resp_valid_q   <= 1'b0;
            resp_rdata_q   <= {`SAC_WORD_W{1'b0}};
            wb_started_q   <= 1'b0;
            mem_wr_start_q <= 1'b0;
            mem_wr_addr_q  <= {`SAC_QADDR_W{1'b0}};
            for (k = 0; k < `SAC_BLOCKS; k = k + 1) begin
                vld_q[k] <= `SAC_FLAGS_RST;
                wrt_q[k] <= `SAC_FLAGS_RST;
            end
            for (k = 0; k < `SAC_LINES; k = k + 1) begin
                use_q[k] <= `SAC_USE_RST;
            end
        end else begin
            resp_valid_q   <= 1'b0;
            mem_wr_start_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (req_valid) begin
                        addr_q  <= req_addr;
                        wr_q    <= req_write;
                        wdata_q <= req_wdata;
                        state_q <= ST_LOOK;
                    end
                end
                ST_LOOK: begin
                    if (vic_dirty) begin
                        way_q        <= victim;
                        wb_started_q <= 1'b0;
                        state_q      <= ST_WB;
                    end else if (wr_q) begin
                        // a store claims the block; a foreign quadword is dropped
                        if (hit_any) begin
                            vld_q[sel_blk] <= sel_vld | word_bit;
                            wrt_q[sel_blk] <= sel_wrt | word_bit;
                        end else begin
                            vld_q[sel_blk] <= word_bit;
                            wrt_q[sel_blk] <= word_bit;
                        end
                        use_q[line]  <= use_touch(use_cur, sel_way);
                        resp_valid_q <= 1'b1;
                        state_q      <= ST_IDLE;
                    end else if (hit_any && sel_vld[wsel]) begin
                        resp_rdata_q <= data_mem[{sel_blk, wsel}];
                        resp_valid_q <= 1'b1;
                        use_q[line]  <= use_touch(use_cur, sel_way);
                        state_q      <= ST_IDLE;
                    end else begin
                        way_q   <= sel_way;
                        first_q <= 1'b1;
                        if (hit_any) begin
                            mask_q <= ~sel_vld;
                        end else begin
                            mask_q         <= 4'hf;
                            vld_q[sel_blk] <= 4'h0;
                            wrt_q[sel_blk] <= 4'h0;
                        end
                        use_q[line] <= use_touch(use_cur, sel_way);
                        state_q     <= ST_FREQ;
                    end
                end
                ST_FREQ: begin
                    if (mem_rd_ready) begin
                        state_q <= ST_FILL;
                    end
                end
                ST_FILL: begin
                    if (mem_rdata_valid) begin
                        // fill words set valid only; written stays as it was
                        vld_q[wb_blk] <= vld_q[wb_blk] | (4'h1 << mem_rdata_word);
                        mask_q <= mask_q & ~(4'h1 << mem_rdata_word);
                        if (first_q) begin
                            first_q      <= 1'b0;
                            resp_rdata_q <= mem_rdata;
                            resp_valid_q <= 1'b1;
                        end
                        if ((mask_q & ~(4'h1 << mem_rdata_word)) == 4'h0) begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_WB: begin
                    if (wb_push) begin
                        wrt_q[wb_blk] <= wb_wrt & ~(4'h1 << wb_idx);
                        if (!wb_started_q) begin
                            wb_started_q   <= 1'b1;
                            mem_wr_start_q <= 1'b1;
                            mem_wr_addr_q  <= {tag_mem[wb_blk], line};
                        end
                    end else if (!(|wb_wrt)) begin
                        state_q <= ST_LOOK;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // memory buffer on the writeback path; a full buffer holds the walk
    sac_fifo #(
        .WIDTH (`SAC_ADDR_W + `SAC_WORD_W),
        .DEPTH (`SAC_MB_DEPTH),
        .AW    (`SAC_MB_AW)
    ) u_mb (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (wb_push_valid),
        .in_ready  (wb_push_ready),
        .in_data   (wb_entry),
        .out_valid (mb_valid),
        .out_ready (mb_ready),
        .out_data  (mb_entry)
    );

    // ==========================================================
    // outputs
    assign req_ready    = (state_q == ST_IDLE);
    assign resp_valid   = resp_valid_q;
    assign resp_rdata   = resp_rdata_q;
    assign mem_rd_valid = (state_q == ST_FREQ);
    assign mem_rd_addr  = addr_q[`SAC_ADDR_W-1:`SAC_LINE_LSB];
    assign mem_rd_first = wsel;
    assign mem_rd_mask  = mask_q;
    assign mem_wr_start = mem_wr_start_q;
    assign mem_wr_addr  = mem_wr_addr_q;
    assign mb_addr      = mb_entry[`SAC_ADDR_W+`SAC_WORD_W-1:`SAC_WORD_W];
    assign mb_data      = mb_entry[`SAC_WORD_W-1:0];

endmodule

// [common/sac_consts.vh]
// constants for the four-way write-back data cache
// assumes inclusion by the cache, its port assertions, the memory model and the bench
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

// ==========================================================
// word and address layout
`define SAC_WORD_W      36
`define SAC_ADDR_W      22
`define SAC_PAGE_MSB    21
`define SAC_PAGE_LSB    9
`define SAC_LINE_MSB    8
`define SAC_LINE_LSB    2
`define SAC_WSEL_MSB    1
`define SAC_WSEL_LSB    0
`define SAC_PAGE_W      13
`define SAC_LINE_W      7
`define SAC_QADDR_W     20

// ==========================================================
// storage sizes
`define SAC_WAYS        4
`define SAC_LINES       128
`define SAC_BLOCKS      512
`define SAC_WORDS       2048

// ==========================================================
// reset values
`define SAC_USE_RST     8'he4
`define SAC_FLAGS_RST   4'h0

// ==========================================================
// memory buffer fifo
`define SAC_MB_DEPTH    4
`define SAC_MB_AW       2

`endif

// [hdl/sac_fifo.v]
// small synchronous fifo used as the memory buffer on the writeback path
// assumes one clock shared by the filling and draining sides
`timescale 1ns/1ps
module sac_fifo #(
    parameter WIDTH = 58,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clock,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW:0]      wr_q;
    reg [AW:0]      rd_q;

    wire push;
    wire pop;

    // extra pointer bit tells full from empty without a counter
    assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    assign out_valid = (wr_q != rd_q);
    assign out_data  = mem_q[rd_q[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge clock) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

endmodule

// [test/sac_cache_props.sv]
// port assertions for the write-back cache
// assumes a bind into sac_cache, one clock, async active-low reset
`timescale 1ns/1ps
`include "sac_consts.vh"
module sac_cache_props (
    input wire                    clock,
    input wire                    rst_n,
    input wire                    req_valid,
    input wire                    req_ready,
    input wire                    req_write,
    input wire                    resp_valid,
    input wire [`SAC_WORD_W-1:0]  resp_rdata,
    input wire                    mem_rd_valid,
    input wire                    mem_rd_ready,
    input wire [3:0]              mem_rd_mask,
    input wire [1:0]              mem_rd_first,
    input wire                    mem_rdata_valid,
    input wire [`SAC_WORD_W-1:0]  mem_rdata,
    input wire                    mem_wr_start,
    input wire                    mb_valid
);
    // ==========================================================
    // helpers: a fill is waiting for its first word; a store is waiting for its response
    reg  fwd_q;
    reg  st_q;
    wire take = req_valid && req_ready;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) fwd_q <= 1'b0;
        else if (mem_rd_valid && mem_rd_ready) fwd_q <= 1'b1;
        else if (mem_rdata_valid) fwd_q <= 1'b0;
    end
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) st_q <= 1'b0;
        else if (take && req_write) st_q <= 1'b1;
        else if (resp_valid) st_q <= 1'b0;
    end
    default clocking dcb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // properties
    a_lookup_first: assert property (take |=> !req_ready && !mem_rd_valid)
        else $error("lookup cycle not held off");
    a_resp_pulse: assert property (resp_valid |=> !resp_valid)
        else $error("response wider than one cycle");
    a_req_answered: assert property (take |-> ##[2:400] resp_valid)
        else $error("request not answered");
    a_store_no_read: assert property (st_q |-> !mem_rd_valid)
        else $error("store caused a memory read");
    a_fill_first: assert property (mem_rd_valid |-> mem_rd_mask[mem_rd_first])
        else $error("requested word not fetched");
    a_fill_forward: assert property (mem_rdata_valid && fwd_q |=>
        resp_valid && resp_rdata == $past(mem_rdata))
        else $error("first fill word not forwarded");
    a_fill_busy: assert property (mem_rdata_valid |-> !req_ready)
        else $error("idle while fill words arrive");
    a_wr_after_push: assert property (mem_wr_start |-> mb_valid ##1 !mem_wr_start)
        else $error("write start without buffered word");
    c_writeback: cover property (mem_wr_start);
    c_store: cover property (take && req_write);
    c_forward: cover property (mem_rdata_valid && fwd_q);
endmodule
bind sac_cache sac_cache_props sac_cache_props_i (
    .clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .mem_rd_valid(mem_rd_valid), .mem_rd_ready(mem_rd_ready), .mem_rd_mask(mem_rd_mask),
    .mem_rd_first(mem_rd_first), .mem_rdata_valid(mem_rdata_valid), .mem_rdata(mem_rdata),
    .mem_wr_start(mem_wr_start), .mb_valid(mb_valid)
);

// [test/sac_mem_model.sv]
// core memory model: serves fill reads and drains the memory buffer
// assumes one read at a time; a word never written reads as its address
`timescale 1ns/1ps
`include "sac_consts.vh"
module sac_mem_model (
    input  wire                    clock,
    input  wire                    mem_rd_valid,
    output wire                    mem_rd_ready,
    input  wire [`SAC_QADDR_W-1:0] mem_rd_addr,
    input  wire [1:0]              mem_rd_first,
    input  wire [3:0]              mem_rd_mask,
    output reg                     mem_rdata_valid,
    output reg  [1:0]              mem_rdata_word,
    output reg  [`SAC_WORD_W-1:0]  mem_rdata,
    input  wire                    mb_valid,
    output wire                    mb_ready,
    input  wire [`SAC_ADDR_W-1:0]  mb_addr,
    input  wire [`SAC_WORD_W-1:0]  mb_data,
    input  wire                    stall,
    input  wire [3:0]              lat
);
    // ==========================================================
    // storage and read engine
    logic [35:0] mem [logic [21:0]];
    logic        busy;
    logic [19:0] q;
    logic [1:0]  f;
    logic [1:0]  w;
    logic [3:0]  m;
    assign mem_rd_ready = mem_rd_valid && !busy;
    assign mb_ready = !stall;
    always @(posedge clock) if (mb_valid && mb_ready) mem[mb_addr] = mb_data;
    function automatic logic [35:0] rd(input logic [21:0] x);
        return mem.exists(x) ? mem[x] : {14'h0, x};
    endfunction
    initial begin
        busy = 1'b0;
        mem_rdata_valid = 1'b0;
        mem_rdata_word = 2'h0;
        mem_rdata = 36'h0;
        forever begin
            @(posedge clock);
            if (mem_rd_valid && mem_rd_ready) begin
                busy <= 1'b1;
                q = mem_rd_addr;
                f = mem_rd_first;
                m = mem_rd_mask;
                repeat (lat) @(posedge clock);
                for (int k = 0; k < 4; k++) begin
                    w = f + k[1:0];
                    if (m[w]) begin
                        mem_rdata_valid <= 1'b1;
                        mem_rdata_word <= w;
                        mem_rdata <= rd({q, w});
                        @(posedge clock);
                    end
                end
                // released data line shows the inverse, not a stale word
                mem_rdata_valid <= 1'b0;
                mem_rdata <= ~mem_rdata;
                busy <= 1'b0;
            end
        end
    end
endmodule

// [test/set_assoc_writeback_cache_bench.sv]
// self-checking bench for sac_cache against the memory model
// assumes the memory model drains the buffer unless stalled
`timescale 1ns/1ps
`include "sac_consts.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module set_assoc_writeback_cache_bench;
    logic        clock, rst_n, req_valid, req_write, stall;
    logic [21:0] req_addr, mb_addr;
    logic [35:0] req_wdata, got, resp_rdata, mem_rdata, mb_data;
    logic [19:0] mem_rd_addr, mem_wr_addr;
    logic [3:0]  mem_rd_mask, lat, last_mask;
    logic [1:0]  mem_rd_first, mem_rdata_word, last_first;
    logic        req_ready, resp_valid, mem_rd_valid, mem_rd_ready, mem_rdata_valid;
    logic        mem_wr_start, mb_valid, mb_ready;
    int          n_mismatch, num_checks, n_rd, n_wst, n_pop, p0, wt;
    logic [1:0]  seq [$];
    logic [35:0] refm [logic [21:0]];
    sac_cache sac_cache_i (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .mem_rd_valid(mem_rd_valid), .mem_rd_ready(mem_rd_ready), .mem_rd_addr(mem_rd_addr),
        .mem_rd_first(mem_rd_first), .mem_rd_mask(mem_rd_mask),
        .mem_rdata_valid(mem_rdata_valid), .mem_rdata_word(mem_rdata_word),
        .mem_rdata(mem_rdata), .mem_wr_start(mem_wr_start), .mem_wr_addr(mem_wr_addr),
        .mb_valid(mb_valid), .mb_ready(mb_ready), .mb_addr(mb_addr), .mb_data(mb_data));
    sac_mem_model sac_mem_model_i (.clock(clock), .mem_rd_valid(mem_rd_valid),
        .mem_rd_ready(mem_rd_ready), .mem_rd_addr(mem_rd_addr), .mem_rd_first(mem_rd_first),
        .mem_rd_mask(mem_rd_mask), .mem_rdata_valid(mem_rdata_valid),
        .mem_rdata_word(mem_rdata_word), .mem_rdata(mem_rdata), .mb_valid(mb_valid),
        .mb_ready(mb_ready), .mb_addr(mb_addr), .mb_data(mb_data), .stall(stall), .lat(lat));
    // ==========================================================
    // monitors and helpers
    always @(posedge clock) begin
        if (mem_rd_valid && mem_rd_ready) begin
            n_rd++;
            last_mask = mem_rd_mask;
            last_first = mem_rd_first;
        end
        if (mem_rdata_valid) seq.push_back(mem_rdata_word);
        if (mem_wr_start) n_wst++;
        if (mb_valid && mb_ready) n_pop++;
    end
    function automatic logic [35:0] wd(input logic [21:0] a);
        return {14'h0, a} ^ 36'ha_5a5a_5a5a;
    endfunction
    function automatic logic [35:0] ex(input logic [21:0] a);
        return refm.exists(a) ? refm[a] : {14'h0, a};
    endfunction
    function automatic logic [21:0] ad(input logic [12:0] p, input logic [1:0] w);
        return {p, 7'h05, w};
    endfunction
    function automatic logic [7:0] sv();
        logic [7:0] v;
        v = 8'h0;
        foreach (seq[i]) v = {v[5:0], seq[i]};
        return v;
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic do_req(input logic wr, input logic [21:0] a, output logic [35:0] d);
        int t;
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= wd(a);
        if (wr) refm[a] = wd(a);
        t = 0;
        do begin
            @(posedge clock);
            t++;
        end while (req_ready !== 1'b1 && t < 500);
        req_valid <= 1'b0;
        do begin
            @(posedge clock);
            t++;
        end while (resp_valid !== 1'b1 && t < 1000);
        if (t >= 1000) begin
            n_mismatch++;
            end_sim();
        end
        d = resp_rdata;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_miss_hit();
        seq = {};
        do_req(1'b0, 22'h00_0c2a, got);
        `CHK("miss data", ex(22'h00_0c2a), got)
        `CHK("miss mask", 4'hf, last_mask)
        p0 = n_rd;
        do_req(1'b0, 22'h00_0c28, got);
        `CHK("hit data", ex(22'h00_0c28), got)
        `CHK("hit reads", p0, n_rd)
        `CHK("fill order", 8'hb1, sv())
    endtask
    task automatic t_partial();
        lat <= 4'h3;
        p0 = n_rd;
        do_req(1'b1, 22'h00_1035, got);
        `CHK("store reads", p0, n_rd)
        seq = {};
        do_req(1'b0, 22'h00_1037, got);
        `CHK("refill data", ex(22'h00_1037), got)
        `CHK("refill mask", 4'hd, last_mask)
        `CHK("refill first", 2'h3, last_first)
        do_req(1'b0, 22'h00_1035, got);
        `CHK("stored word", wd(22'h00_1035), got)
        `CHK("refill order", 8'h32, sv())
    endtask
    task automatic t_evict();
        for (int w = 0; w < 4; w++) do_req(1'b1, ad(13'h1, w[1:0]), got);
        for (int p = 2; p < 5; p++) do_req(1'b1, ad(p[12:0], 2'h0), got);
        `CHK("no write through", 0, n_pop)
        do_req(1'b0, ad(13'h1, 2'h0), got);
        stall <= 1'b1;
        p0 = n_wst;
        do_req(1'b0, ad(13'h5, 2'h1), got);
        `CHK("evict data", ex(ad(13'h5, 2'h1)), got)
        `CHK("wr start", p0 + 1, n_wst)
        `CHK("wb addr", {13'h2, 7'h05}, mem_wr_addr)
        `CHK("held entry", 1'b1, mb_valid)
        `CHK("victim addr", ad(13'h2, 2'h0), mb_addr)
        `CHK("victim data", wd(ad(13'h2, 2'h0)), mb_data)
        stall <= 1'b0;
        for (int p = 3; p < 6; p++) do_req(1'b0, ad(p[12:0], 2'h0), got);
        stall <= 1'b1;
        p0 = n_pop;
        do_req(1'b0, ad(13'h2, 2'h0), got);
        `CHK("returned word", wd(ad(13'h2, 2'h0)), got)
        `CHK("full buffer", p0, n_pop)
        stall <= 1'b0;
        wt = 0;
        do begin
            @(posedge clock);
            wt++;
        end while (mb_valid !== 1'b0 && wt < 40);
        if (wt >= 40) begin
            n_mismatch++;
            end_sim();
        end
        `CHK("drained words", p0 + 4, n_pop)
        do_req(1'b0, ad(13'h1, 2'h2), got);
        `CHK("written back", wd(ad(13'h1, 2'h2)), got)
    endtask
    // ==========================================================
    // clock and main sequence
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 22'h0;
        req_wdata = 36'h0;
        stall = 1'b0;
        lat = 4'h0;
        repeat (3) @(posedge clock);
        `CHK("reset ready", 1'b1, req_ready)
        `CHK("reset buffer", 1'b0, mb_valid)
        rst_n <= 1'b1;
        t_miss_hit();
        t_partial();
        t_evict();
        end_sim();
    end
endmodule
